// File: hdl/lil_los_if.sv
// Purpose: carrier between loss-of-signal monitor and the top
// Assumes: all signals on the recovered clock domain or static
// Notes: settings are quasi static
`timescale 1ns/10ps
`default_nettype none
interface lil_los_if;
   logic [7:0] absence_n;
   logic [7:0] density_n;
   logic pulse;
   logic alarm;
   modport mon (input absence_n, input density_n, input pulse,
      output alarm);
   modport top (output absence_n, output density_n, output pulse,
      input alarm);
endinterface
`default_nettype wire

// File: hdl/lil_los_mon.sv
// Purpose: loss-of-signal detect and recovery counters
// Assumes: clk is the recovered receive clock, one tick per pulse slot
// Notes: pulse means a one on either rail, for analog and digital alike
`timescale 1ns/10ps
`default_nettype none
module lil_los_mon (
   input wire logic clk,
   input wire logic rst_n,
   lil_los_if.mon lp
);
   logic [11:0] absent_reg;
   logic [11:0] window_reg;
   logic [8:0] count_reg;
   logic in_win_reg;
   logic alarm_reg;
   logic [11:0] limit;
   assign limit = {lp.absence_n, 4'h0} + (lil_pkg::ABS_BLOCK - 12'h001);
   assign lp.alarm = alarm_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         absent_reg <= 12'h000;
      end else if (lp.pulse) begin
         absent_reg <= 12'h000;
      end else if (absent_reg != limit) begin
         absent_reg <= absent_reg + 12'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_reg <= 1'b0;
      end else if (!alarm_reg && !lp.pulse && absent_reg == limit) begin
         alarm_reg <= 1'b1;
      end else if (alarm_reg && lp.pulse &&
         (in_win_reg ? count_reg : 9'h000) >= {1'b0, lp.density_n}) begin
         alarm_reg <= 1'b0;
      end
   end

   // recovery window restarts only at a pulse, so idle line keeps alarm
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_win_reg <= 1'b0;
         window_reg <= 12'h000;
         count_reg <= 9'h000;
      end else if (!alarm_reg) begin
         in_win_reg <= 1'b0;
         count_reg <= 9'h000;
      end else if (in_win_reg && window_reg == limit) begin
         in_win_reg <= 1'b0;
         count_reg <= 9'h000;
      end else if (in_win_reg) begin
         window_reg <= window_reg + 12'h001;
         if (lp.pulse) begin
            count_reg <= count_reg + 9'h001;
         end
      end else if (lp.pulse) begin
         in_win_reg <= 1'b1;
         window_reg <= 12'h000;
         count_reg <= 9'h001;
      end
   end
endmodule // lil_los_mon
`default_nettype wire

// File: hdl/lil_pkg.sv
// Purpose: constants for the line interface and loss-of-signal block
// Assumes: AHB-Lite register port, 32-bit words, byte offsets = index*4
// Notes: offsets below are register indices
package lil_pkg;
   localparam logic [7:0] IDX_MODE1 = 8'h35;
   localparam logic [7:0] IDX_ABSENCE = 8'h36;
   localparam logic [7:0] IDX_RECOVERY = 8'h37;
   localparam logic [7:0] IDX_FREEZE = 8'h38;
   localparam logic [7:0] IDX_FEC_LOW = 8'h50;
   localparam logic [7:0] IDX_FEC_HIGH = 8'h51;
   localparam logic [7:0] IDX_STATUS = 8'h4C;
   localparam logic [7:0] IDX_CONTROL = 8'h39;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int BIT_FRAME_PULSE = 7;
   localparam int BIT_THR_HI = 6;
   localparam int BIT_THR_LO = 4;
   localparam int BIT_TX_JITTER_ATTEN_ENABLE = 2;
   localparam int BIT_LOOP = 1;
   localparam int BIT_DUAL = 0;
   localparam int BIT_FREEZE = 0;
   localparam int BIT_MASTER = 0;
   localparam int BIT_ECM = 1;
   localparam int BIT_LOS = 0;
   localparam int BIT_LOS_STICKY = 1;
   localparam int BIT_REF_LOCK = 2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD = 3'b010;
   localparam logic [11:0] ABS_BLOCK = 12'h010;
   // long enough window to see several reference periods
   localparam int REF_WIN = 512;
   localparam logic [8:0] REF_WIN_LAST = 9'h1FF;
   localparam logic [6:0] REF_EDGES_LO = 7'h07;
   localparam logic [6:0] REF_EDGES_HI = 7'h0A;
   // 8 kHz frame pulse period in register clock cycles, minus one
   localparam logic [13:0] FP_DIV_LAST = 14'h3D08;
   typedef enum logic [1:0] {
      LIL_JL_NORMAL = 2'b00,
      LIL_JL_LOOP = 2'b01,
      LIL_JL_SLICER = 2'b10,
      LIL_JL_LOOP_JA = 2'b11
   } lil_jl_t;
endpackage

// File: hdl/lil_top.sv
// Purpose: line interface control and loss-of-signal supervision
// Assumes: hclk 125 MHz; rx_recovered_clock is a second clock only for
//    the loss monitor; line inputs are synchronised here
// Notes: analog front end is abstracted to a digital slice per rail
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - master bit with reference idle: run free and drive system clocks
// - master with 2.048 MHz seen on reference pin: lock to it
// - frame pulse bit clear gives transmit clock, set gives 8 kHz pulse
// - threshold code only matters on analog interface for no-signal
// - field 00: normal, attenuator off, transmit bypasses buffer
// - field 01: remote loop without attenuator
// - field 10: highway data through attenuator buffer to line
// - field 11: remote loop through attenuator buffer
// - dual rail clear: analog ternary pins used
// - dual rail set: dual rail pins latch and drive data
// - alarm after 16(N+1) pulse slots without a pulse
// - any pulse resets no-pulse counter, clocked by recovered clock
// - alarm clears only after N+1 pulses in one interval
// - interval starts at a pulse, counts pulses, compares threshold
// - short interval keeps alarm, next pulse starts new interval
// - freeze clears itself once counter high byte is read
// - freeze rising edge latches count then clears running counter
// - rising alarm sets the sticky loss status bit
// - digital interface counts zeros for loss, ones for recovery
module lil_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ext_reference_clock_pin,
   input wire logic rx_recovered_clock,
   input wire logic [1:0] rx_analog_line_pins,
   input wire logic [1:0] rx_dual_rail_inputs,
   input wire logic tx_highway_data_in,
   input wire logic tx_bit_strobe,
   input wire logic framing_error_event,
   output logic [1:0] tx_analog_line_pins,
   output logic [1:0] tx_dual_rail_outputs,
   output logic tx_clock_output,
   output logic system_clock_outputs,
   output logic [2:0] rx_input_threshold,
   output logic signal_loss_alarm
);
   logic [7:0] mode1_reg;
   logic [7:0] absence_reg;
   logic [7:0] recovery_reg;
   logic [7:0] control_reg;
   logic freeze_reg;
   logic freeze_d_reg;
   logic los_sticky_reg;
   logic [15:0] fec_run_reg;
   logic [15:0] fec_latch_reg;
   logic wr_pend_reg;
   logic rd_pend_reg;
   logic [7:0] idx_reg;
   logic [2:0] ref_sync_reg;
   logic [2:0] los_sync_reg;
   logic [2:0] rxa_p_reg, rxa_n_reg, rxd_p_reg, rxd_n_reg;
   logic [8:0] ref_cnt_reg;
   logic [6:0] ref_edges_reg;
   logic ref_lock_reg;
   logic ref_lvl_reg;
   logic [13:0] div_reg;
   logic sysclk_reg;
   logic [1:0] ja_buf_reg;
   logic rx_p, rx_n;
   logic [1:0] rx_prev_r;
   logic [7:0] idx_now;
   logic take;
   logic [1:0] tx_next;
   lil_pkg::lil_jl_t jl;
   lil_los_if lif ();

   assign idx_now = haddr[9:2];
   assign take = hsel && hready && htrans == lil_pkg::HTRANS_NONSEQ &&
      hsize == lil_pkg::HSIZE_WORD;
   assign jl = lil_pkg::lil_jl_t'(mode1_reg[lil_pkg::BIT_TX_JITTER_ATTEN_ENABLE:
      lil_pkg::BIT_LOOP]);

   // single cycle slave, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         idx_reg <= lil_pkg::RESET_BYTE;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (hready) begin
         wr_pend_reg <= take && hwrite;
         rd_pend_reg <= take && !hwrite;
         if (take) begin
            idx_reg <= idx_now;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hrdata <= 32'h0000_0000;
         unique case (idx_now)
            lil_pkg::IDX_MODE1: hrdata[7:0] <= mode1_reg;
            lil_pkg::IDX_ABSENCE: hrdata[7:0] <= absence_reg;
            lil_pkg::IDX_RECOVERY: hrdata[7:0] <= recovery_reg;
            lil_pkg::IDX_CONTROL: hrdata[7:0] <= control_reg;
            lil_pkg::IDX_FEC_LOW: hrdata[7:0] <= fec_latch_reg[7:0];
            lil_pkg::IDX_FEC_HIGH: hrdata[7:0] <= fec_latch_reg[15:8];
            lil_pkg::IDX_STATUS: begin
               hrdata[lil_pkg::BIT_LOS] <= signal_loss_alarm;
               hrdata[lil_pkg::BIT_LOS_STICKY] <= los_sticky_reg;
               hrdata[lil_pkg::BIT_REF_LOCK] <= ref_lock_reg;
            end
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode1_reg <= lil_pkg::RESET_BYTE;
         absence_reg <= lil_pkg::RESET_BYTE;
         recovery_reg <= lil_pkg::RESET_BYTE;
         control_reg <= lil_pkg::RESET_BYTE;
      end else if (wr_pend_reg) begin
         unique case (idx_reg)
            lil_pkg::IDX_MODE1: mode1_reg <= hwdata[7:0];
            lil_pkg::IDX_ABSENCE: absence_reg <= hwdata[7:0];
            lil_pkg::IDX_RECOVERY: recovery_reg <= hwdata[7:0];
            lil_pkg::IDX_CONTROL: control_reg <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // freeze: write-one sets, high byte read clears; only valid in mode 0
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         freeze_reg <= 1'b0;
      end else if (wr_pend_reg && idx_reg == lil_pkg::IDX_FREEZE &&
         hwdata[lil_pkg::BIT_FREEZE] && !control_reg[lil_pkg::BIT_ECM]) begin
         freeze_reg <= 1'b1;
      end else if (rd_pend_reg && idx_reg == lil_pkg::IDX_FEC_HIGH) begin
         freeze_reg <= 1'b0;
      end
   end

   // error arriving at latch time counts in the fresh counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         freeze_d_reg <= 1'b0;
         fec_run_reg <= 16'h0000;
         fec_latch_reg <= 16'h0000;
      end else begin
         freeze_d_reg <= freeze_reg;
         if (freeze_reg && !freeze_d_reg) begin
            fec_latch_reg <= fec_run_reg;
            fec_run_reg <= {15'h0000, framing_error_event};
         end else if (framing_error_event && fec_run_reg != 16'hFFFF) begin
            fec_run_reg <= fec_run_reg + 16'h0001;
         end
      end
   end

   // pin synchronisers: use only stages 1 and 2 for decisions
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_sync_reg <= 3'b000;
         los_sync_reg <= 3'b000;
         rxa_p_reg <= 3'b000;
         rxa_n_reg <= 3'b000;
         rxd_p_reg <= 3'b000;
         rxd_n_reg <= 3'b000;
      end else begin
         ref_sync_reg <= {ref_sync_reg[1:0], ext_reference_clock_pin};
         los_sync_reg <= {los_sync_reg[1:0], lif.alarm};
         rxa_p_reg <= {rxa_p_reg[1:0], rx_analog_line_pins[1]};
         rxa_n_reg <= {rxa_n_reg[1:0], rx_analog_line_pins[0]};
         rxd_p_reg <= {rxd_p_reg[1:0], rx_dual_rail_inputs[1]};
         rxd_n_reg <= {rxd_n_reg[1:0], rx_dual_rail_inputs[0]};
      end
   end

   // reference detect: count agreed rising edges per 512-cycle window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_cnt_reg <= 9'h000;
         ref_edges_reg <= 7'h00;
         ref_lock_reg <= 1'b0;
         ref_lvl_reg <= 1'b0;
      end else begin
         ref_cnt_reg <= (ref_cnt_reg == lil_pkg::REF_WIN_LAST) ? 9'h000 :
            ref_cnt_reg + 9'h001;
         if (ref_sync_reg[1] == ref_sync_reg[2]) begin
            ref_lvl_reg <= ref_sync_reg[2];
         end
         if (ref_cnt_reg == lil_pkg::REF_WIN_LAST) begin
            ref_edges_reg <= 7'h00;
            ref_lock_reg <= control_reg[lil_pkg::BIT_MASTER] &&
               ref_edges_reg >= lil_pkg::REF_EDGES_LO &&
               ref_edges_reg <= lil_pkg::REF_EDGES_HI;
         end else if (ref_sync_reg[1] && ref_sync_reg[2] &&
            !ref_lvl_reg) begin
            ref_edges_reg <= ref_edges_reg + 7'h01;
         end
      end
   end

   // system clock: divided local clock, replaced by the reference level on lock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_reg <= 14'h0000;
         sysclk_reg <= 1'b0;
         tx_clock_output <= 1'b0;
         system_clock_outputs <= 1'b0;
      end else begin
         div_reg <= (div_reg == lil_pkg::FP_DIV_LAST) ? 14'h0000 :
            div_reg + 14'h0001;
         if (ref_lock_reg) begin
            sysclk_reg <= ref_lvl_reg;
         end else if (control_reg[lil_pkg::BIT_MASTER]) begin
            sysclk_reg <= ~sysclk_reg;
         end
         system_clock_outputs <= sysclk_reg;
         tx_clock_output <= mode1_reg[lil_pkg::BIT_FRAME_PULSE] ?
            (div_reg == lil_pkg::FP_DIV_LAST) : sysclk_reg;
      end
   end

   // receive slice: dual rail or analog pins, two agreeing stages
   assign rx_p = mode1_reg[lil_pkg::BIT_DUAL] ?
      (rxd_p_reg[1] & rxd_p_reg[2]) : (rxa_p_reg[1] & rxa_p_reg[2]);
   assign rx_n = mode1_reg[lil_pkg::BIT_DUAL] ?
      (rxd_n_reg[1] & rxd_n_reg[2]) : (rxa_n_reg[1] & rxa_n_reg[2]);

   always_comb begin
      unique case (jl)
         lil_pkg::LIL_JL_NORMAL: tx_next = {tx_highway_data_in, 1'b0};
         lil_pkg::LIL_JL_LOOP: tx_next = {rx_p, rx_n};
         lil_pkg::LIL_JL_SLICER: tx_next = ja_buf_reg;
         lil_pkg::LIL_JL_LOOP_JA: tx_next = ja_buf_reg;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ja_buf_reg <= 2'b00;
         tx_analog_line_pins <= 2'b00;
         tx_dual_rail_outputs <= 2'b00;
         rx_input_threshold <= 3'b000;
      end else begin
         if (tx_bit_strobe) begin
            ja_buf_reg <= jl[0] ? {rx_p, rx_n} : {tx_highway_data_in, 1'b0};
            tx_analog_line_pins <= mode1_reg[lil_pkg::BIT_DUAL] ? 2'b00 :
               tx_next;
            tx_dual_rail_outputs <= mode1_reg[lil_pkg::BIT_DUAL] ? tx_next :
               2'b00;
         end
         rx_input_threshold <= mode1_reg[lil_pkg::BIT_DUAL] ? 3'b000 :
            mode1_reg[lil_pkg::BIT_THR_HI:lil_pkg::BIT_THR_LO];
      end
   end

   // recovered-clock side: pulse detection and the loss monitor
   always_ff @(posedge rx_recovered_clock or negedge hresetn) begin
      if (!hresetn) begin
         rx_prev_r <= 2'b00;
      end else begin
         rx_prev_r <= mode1_reg[lil_pkg::BIT_DUAL] ? rx_dual_rail_inputs :
            rx_analog_line_pins;
      end
   end
   assign lif.pulse = mode1_reg[lil_pkg::BIT_DUAL] ?
      (|rx_prev_r) : (rx_prev_r != 2'b00);
   assign lif.absence_n = absence_reg;
   assign lif.density_n = recovery_reg;

   lil_los_mon u_mon (
      .clk(rx_recovered_clock),
      .rst_n(hresetn),
      .lp(lif.mon)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         los_sticky_reg <= 1'b0;
         signal_loss_alarm <= 1'b0;
      end else begin
         // alarm moves only once the last two sync stages agree
         if (los_sync_reg[1] == los_sync_reg[2]) begin
            signal_loss_alarm <= los_sync_reg[2];
         end
         if (los_sync_reg[1] && los_sync_reg[2] && !signal_loss_alarm) begin
            los_sticky_reg <= 1'b1;
         end else if (rd_pend_reg && idx_reg == lil_pkg::IDX_STATUS) begin
            los_sticky_reg <= 1'b0;
         end
      end
   end
endmodule // lil_top
`default_nettype wire

// File: verification/lil_line_model.sv
// Purpose: far-end line model feeding the receive side
// Assumes: one mark or space per recovered clock slot
// Notes: marks alternate rails so each mark is also a transition
`timescale 1ns/10ps
`default_nettype none
module lil_line_model (
   input wire logic marks_on,
   output logic rx_clk,
   output logic [1:0] rails
);
   logic alt;
   // offset keeps slot edges clear of the register clock edges
   initial begin
      rx_clk = 1'b0;
      rails = 2'b00;
      alt = 1'b0;
      #3;
      forever #24 rx_clk = ~rx_clk;
   end
   // data moves on the falling edge so the receiver samples it settled
   always @(negedge rx_clk) begin
      alt <= ~alt;
      rails <= marks_on ? {alt, ~alt} : 2'b00;
   end
endmodule // lil_line_model
`default_nettype wire

// File: verification/lil_top_chk.sv
// Purpose: port-level checks for lil_top
// Assumes: one hclk domain, zero-wait register port
// Notes: ages saturate so a long idle spell never wraps to zero
`timescale 1ns/10ps
`default_nettype none
module lil_top_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic tx_bit_strobe,
   input wire logic [1:0] tx_dual_rail_outputs,
   input wire logic [2:0] rx_input_threshold,
   input wire logic signal_loss_alarm,
   input wire logic [1:0] rx_dual_rail_inputs
);
   logic acc;
   logic [2:0] wr_age;
   logic [2:0] rd_age;
   logic [2:0] stb_age;
   function automatic logic [2:0] sat(input logic [2:0] a);
      return (a == 3'h7) ? a : a + 3'h1;
   endfunction
   assign acc = hsel && hready && htrans == lil_pkg::HTRANS_NONSEQ &&
      hsize == lil_pkg::HSIZE_WORD;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_age <= 3'h7;
         rd_age <= 3'h7;
         stb_age <= 3'h7;
      end else begin
         wr_age <= (acc && hwrite) ? 3'h0 : sat(wr_age);
         rd_age <= (acc && !hwrite) ? 3'h0 : sat(rd_age);
         stb_age <= tx_bit_strobe ? 3'h0 : sat(stb_age);
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_at(lo, hi);
      acc && !hwrite && haddr[31:10] == '0 && haddr[1:0] == '0 &&
         haddr[9:2] >= lo && haddr[9:2] <= hi;
   endsequence
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("register port not ready or not okay");
   unmapped_zero_a: assert property (rd_at(8'h00, 8'h34) |=> hrdata == '0)
      else $error("unmapped read not zero");
   byte_upper_a: assert property (rd_at(lil_pkg::IDX_MODE1,
      lil_pkg::IDX_RECOVERY) |=> hrdata[31:8] == '0)
      else $error("register read with upper bits set");
   thr_write_a: assert property ($changed(rx_input_threshold) |->
      wr_age <= 3'h3) else $error("threshold moved without a write");
   tx_strobe_a: assert property ($changed(tx_dual_rail_outputs) |->
      stb_age <= 3'h3) else $error("line output moved without strobe");
   rdata_hold_a: assert property ($changed(hrdata) |-> rd_age == 3'h0)
      else $error("read data changed without a read");
   los_quiet_a: assert property ($rose(signal_loss_alarm) |->
      $past(rx_dual_rail_inputs, 8) == 2'b00)
      else $error("loss alarm rose while line active");
   los_live_a: assert property ($fell(signal_loss_alarm) |->
      $past(rx_dual_rail_inputs, 12) != 2'b00)
      else $error("loss alarm cleared while line quiet");
endmodule // lil_top_chk
bind lil_top lil_top_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hsize, .hready, .hrdata, .hreadyout, .hresp, .tx_bit_strobe,
   .tx_dual_rail_outputs, .rx_input_threshold, .signal_loss_alarm,
   .rx_dual_rail_inputs);
`default_nettype wire

// File: verification/line_interface_los_control_tb.sv
// Purpose: self-checking bench for lil_top
// Assumes: zero-wait AHB-Lite slave, line model on the receive side
// Notes: loss timing is judged in recovered clock slots
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
   compares++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("mismatch %s exp %0h got %0h", nm, exp, got); \
   end
module line_interface_los_control_tb;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, ext_ref, rx_clk;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic [1:0] htrans, rails, tx_an, tx_dr;
   logic [2:0] hsize, thr;
   logic marks_on, highway, strobe, fe_event, tx_clk, sys_clk, alarm;
   logic ref_on;
   int cyc = 0;
   int err_count, compares;
   lil_line_model u_line (.marks_on(marks_on), .rx_clk(rx_clk),
      .rails(rails));
   lil_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .ext_reference_clock_pin(ext_ref),
      .rx_recovered_clock(rx_clk), .rx_analog_line_pins(rails),
      .rx_dual_rail_inputs(rails), .tx_highway_data_in(highway),
      .tx_bit_strobe(strobe), .framing_error_event(fe_event),
      .tx_analog_line_pins(tx_an), .tx_dual_rail_outputs(tx_dr),
      .tx_clock_output(tx_clk), .system_clock_outputs(sys_clk),
      .rx_input_threshold(thr), .signal_loss_alarm(alarm));
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // the reference is built from hclk, close enough to 2.048 MHz
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      strobe <= (cyc % 8 == 0);
      highway <= cyc[4];
      if (!ref_on) ext_ref <= 1'b0;
      else if (cyc % 30 == 0) ext_ref <= ~ext_ref;
      if (cyc == 50000) begin
         err_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic xfer(input logic wr, input logic [7:0] idx,
         input logic [7:0] wd);
      hsel <= 1'b1;
      haddr <= {{22{1'b0}}, idx, 2'b00};
      htrans <= lil_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= lil_pkg::HSIZE_WORD;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, wd};
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp,
         input string nm);
      xfer(1'b0, idx, 8'h00);
      `CHK(nm, exp, rd)
   endtask
   task automatic t_regs();
      rchk(lil_pkg::IDX_MODE1, 32'h0000_0000, "mode1 reset");
      rchk(lil_pkg::IDX_ABSENCE, 32'h0000_0000, "absence reset");
      rchk(lil_pkg::IDX_RECOVERY, 32'h0000_0000, "recovery reset");
      xfer(1'b1, 8'h12, 8'hFF);
      rchk(8'h12, 32'h0000_0000, "unmapped");
      xfer(1'b1, lil_pkg::IDX_ABSENCE, 8'hA5);
      xfer(1'b1, lil_pkg::IDX_RECOVERY, 8'h5A);
      rchk(lil_pkg::IDX_ABSENCE, 32'h0000_00A5, "absence rw");
      rchk(lil_pkg::IDX_RECOVERY, 32'h0000_005A, "recovery rw");
      xfer(1'b1, lil_pkg::IDX_MODE1, 8'h50);
      rchk(lil_pkg::IDX_MODE1, 32'h0000_0050, "mode1 rw");
      `CHK("threshold", 3'h5, thr)
      xfer(1'b1, lil_pkg::IDX_MODE1, 8'h51);
      repeat (3) @(posedge hclk);
      `CHK("threshold dual", 3'h0, thr)
   endtask
   task automatic t_fp(input logic [7:0] m, input int lo, input int hi,
         input string nm);
      int n = 0;
      xfer(1'b1, lil_pkg::IDX_MODE1, m);
      repeat (8) @(posedge hclk);
      // one full frame pulse period
      repeat (int'(lil_pkg::FP_DIV_LAST) + 1) begin
         @(posedge hclk);
         n += (tx_clk === 1'b1);
      end
      `CHK(nm, 1'b1, (n >= lo && n <= hi))
   endtask
   task automatic t_tx(input logic [7:0] m, input int lag,
         input string nm);
      logic h;
      xfer(1'b1, lil_pkg::IDX_MODE1, m);
      do @(posedge hclk); while (strobe !== 1'b1);
      h = highway;
      // buffered path shows the bit one strobe later, strobes 8 apart
      repeat (lag * 8) @(posedge hclk);
      @(posedge hclk);
      `CHK(nm, {h, 1'b0}, (m[0] ? tx_dr : tx_an))
      `CHK("idle rails", 2'b00, (m[0] ? tx_an : tx_dr))
   endtask
   task automatic t_ref();
      int n = 0;
      xfer(1'b1, lil_pkg::IDX_CONTROL, 8'h01);
      ref_on <= 1'b1;
      repeat (1200) @(posedge hclk);
      rchk(lil_pkg::IDX_STATUS, 32'h0000_0004, "ref lock");
      ref_on <= 1'b0;
      repeat (1200) @(posedge hclk);
      rchk(lil_pkg::IDX_STATUS, 32'h0000_0000, "free run");
      repeat (64) begin
         @(posedge hclk);
         n += (sys_clk === 1'b1);
      end
      `CHK("sys clock", 32, n)
   endtask
   task automatic t_los(input logic [7:0] n, input logic [7:0] m1);
      int t = 16 * (n + 1);
      xfer(1'b1, lil_pkg::IDX_MODE1, m1);
      xfer(1'b1, lil_pkg::IDX_ABSENCE, n);
      xfer(1'b1, lil_pkg::IDX_RECOVERY, 8'h03);
      marks_on <= 1'b1;
      repeat (12) @(posedge rx_clk);
      `CHK("alarm clear", 1'b0, alarm)
      marks_on <= 1'b0;
      repeat (t - 4) @(posedge rx_clk);
      `CHK("alarm early", 1'b0, alarm)
      repeat (8) @(posedge rx_clk);
      `CHK("alarm set", 1'b1, alarm)
      rchk(lil_pkg::IDX_STATUS, 32'h0000_0003, "status rise");
      rchk(lil_pkg::IDX_STATUS, 32'h0000_0001, "status read");
      marks_on <= 1'b1;
      repeat (2) @(posedge rx_clk);
      marks_on <= 1'b0;
      repeat (6) @(posedge rx_clk);
      `CHK("alarm short", 1'b1, alarm)
   endtask
   task automatic ev(input int k);
      repeat (k) begin
         fe_event <= 1'b1;
         @(posedge hclk);
         fe_event <= 1'b0;
         @(posedge hclk);
      end
   endtask
   task automatic t_frz();
      xfer(1'b1, lil_pkg::IDX_CONTROL, 8'h00);
      ev(5);
      // latch lands one cycle after the freeze bit rises
      xfer(1'b1, lil_pkg::IDX_FREEZE, 8'h01);
      @(posedge hclk);
      rchk(lil_pkg::IDX_FEC_LOW, 32'h0000_0005, "count latch");
      rchk(lil_pkg::IDX_FEC_HIGH, 32'h0000_0000, "count high");
      ev(3);
      xfer(1'b1, lil_pkg::IDX_FREEZE, 8'h01);
      @(posedge hclk);
      rchk(lil_pkg::IDX_FEC_LOW, 32'h0000_0003, "count relatch");
      rchk(lil_pkg::IDX_FEC_HIGH, 32'h0000_0000, "count high");
      xfer(1'b1, lil_pkg::IDX_CONTROL, 8'h02);
      ev(2);
      xfer(1'b1, lil_pkg::IDX_FREEZE, 8'h01);
      @(posedge hclk);
      rchk(lil_pkg::IDX_FEC_LOW, 32'h0000_0003, "count mode");
   endtask
   initial begin
      {hresetn, hsel, hwrite, htrans, hsize, ref_on} = '0;
      {haddr, hwdata, fe_event} = '0;
      {err_count, compares} = '0;
      marks_on = 1'b1;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_tx(8'h00, 0, "tx normal");
      t_tx(8'h05, 1, "tx buffered");
      // master mode so the local clock runs for the transmit clock
      xfer(1'b1, lil_pkg::IDX_CONTROL, 8'h01);
      t_fp(8'h80, 1, 1, "frame pulses");
      t_fp(8'h00, 7812, 7813, "tx clock");
      t_ref();
      t_los(8'h00, 8'h01);
      t_los(8'h01, 8'h00);
      t_frz();
      print_verdict();
   end
endmodule // line_interface_los_control_tb
`default_nettype wire
